// file: logic/rsr_alu_pkg.sv
// rsr_alu_pkg: constants and types shared by the rotate/subtract/return unit.
// assumes byte addresses on the register bus and a one-cycle read latency on the operand port.
package rsr_alu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [7:0] OP_RET      = 8'hAF;
  localparam logic [7:0] OP_RL_R     = 8'h90;
  localparam logic [7:0] OP_RL_IR    = 8'h91;
  localparam logic [7:0] OP_RLC_R    = 8'h10;
  localparam logic [7:0] OP_RLC_IR   = 8'h11;
  localparam logic [7:0] OP_RR_R     = 8'hE0;
  localparam logic [7:0] OP_RR_IR    = 8'hE1;
  localparam logic [7:0] OP_RRC_R    = 8'hC0;
  localparam logic [7:0] OP_RRC_IR   = 8'hC1;
  localparam logic [7:0] OP_SBC_RR   = 8'h32;
  localparam logic [7:0] OP_SBC_RIR  = 8'h33;
  localparam logic [7:0] OP_SBC_RR8  = 8'h34;
  localparam logic [7:0] OP_SBC_RIR8 = 8'h35;
  localparam logic [7:0] OP_SBC_RIM  = 8'h36;
  localparam logic [7:0] OP_SBC_IRIM = 8'h37;

  ////////////////////////////////////////////////////////////////////////////
  // flag bit positions inside the flags byte
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte offsets) and reset values
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_FLAGS   = 4'h4;
  localparam logic [3:0]  REG_STATUS  = 4'h8;
  localparam logic [3:0]  REG_COUNT   = 4'hC;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic        CTRL_RST    = 1'h1;
  localparam logic [7:0]  FLAGS_RST   = 8'h00;
  localparam logic [15:0] STACK_STEP  = 16'h0002;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_RPTR = 10'h002,
    ST_CPTR = 10'h004,
    ST_ROPA = 10'h008,
    ST_CDST = 10'h010,
    ST_CSPT = 10'h020,
    ST_RSRC = 10'h040,
    ST_CSRC = 10'h080,
    ST_STKH = 10'h100,
    ST_STKL = 10'h200
  } rsr_state_type;

endpackage

// file: logic/rsr_alu.sv
// rsr_alu: executes return, the four single-bit rotates and subtract-with-borrow.
// assumes the decoder resolves operand fields to 8-bit register addresses, and the
// operand port returns read data one cycle after memRe, on this same clock.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module rsr_alu (
  input  wire logic        clk,           // core clock, 100 MHz
  input  wire logic        rst_n,         // async reset, active low
  input  wire logic        instrValid,    // decoder offers an instruction
  output logic             instrReady,    // unit idle and enabled
  input  wire logic [7:0]  opcode,        // instruction opcode
  input  wire logic [7:0]  dstField,      // destination register address
  input  wire logic [7:0]  srcField,      // source register address or immediate
  input  wire logic [15:0] spIn,          // current stack pointer
  output logic             instrDone,     // pulse: instruction finished
  output logic             instrIllegal,  // pulse with instrDone: opcode not handled
  output logic             memRe,         // operand read strobe
  output logic             memWe,         // operand write strobe
  output logic [15:0]      memAddr,       // operand / stack address
  output logic [7:0]       memWrData,     // operand write data
  input  wire logic [7:0]  memRdData,     // read data, one cycle after memRe
  output logic             pcLoad,        // pulse: load pcOut into pc
  output logic [15:0]      pcOut,         // new program counter
  output logic             spLoad,        // pulse: load spOut into sp
  output logic [15:0]      spOut,         // new stack pointer
  output logic [7:0]       flagsOut,      // current flags byte
  input  wire logic [3:0]  avs_address,   // avalon byte address
  input  wire logic        avs_read,      // avalon read
  input  wire logic        avs_write,     // avalon write
  input  wire logic [3:0]  avs_byteenable,// avalon byte enables
  input  wire logic [31:0] avs_writedata, // avalon write data
  output logic [31:0]      avs_readdata,  // avalon read data
  output logic             avs_waitrequest // avalon wait
);
  import rsr_alu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // opcode classification
  function automatic logic isRot(input logic [7:0] op);
    return op inside {OP_RL_R, OP_RL_IR, OP_RLC_R, OP_RLC_IR, OP_RR_R, OP_RR_IR, OP_RRC_R, OP_RRC_IR};
  endfunction

  function automatic logic isSbc(input logic [7:0] op);
    return op inside {OP_SBC_RR, OP_SBC_RIR, OP_SBC_RR8, OP_SBC_RIR8, OP_SBC_RIM, OP_SBC_IRIM};
  endfunction

  // destination reached through a pointer register
  function automatic logic dstInd(input logic [7:0] op);
    return (isRot(op) && op[0]) || op == OP_SBC_IRIM;
  endfunction

  // result and flags: {flags, result}
  function automatic logic [15:0] aluCalc(input logic [7:0] op, input logic [7:0] dVal,
                                          input logic [7:0] sVal, input logic [7:0] flg);
    logic [7:0] res;
    logic [7:0] f;
    logic [8:0] sum;
    logic [4:0] low;
    logic       cIn;
    res = dVal;
    f   = flg;
    cIn = flg[FLAG_C];
    sum = 9'h000;
    low = 5'h00;
    // d and h stay as they were for every rotate
    if (op == OP_RL_R || op == OP_RL_IR) begin
      res = {dVal[6:0], dVal[7]};
    end else if (op == OP_RLC_R || op == OP_RLC_IR) begin
      res = {dVal[6:0], cIn};
    end else if (op == OP_RR_R || op == OP_RR_IR) begin
      res = {dVal[0], dVal[7:1]};
    end else if (op == OP_RRC_R || op == OP_RRC_IR) begin
      res = {cIn, dVal[7:1]};
    end
    if (isRot(op)) begin
      // opcode bit 6 marks the right rotates, whose carry comes from bit 0
      f[FLAG_C] = op[6] ? dVal[0] : dVal[7];
      f[FLAG_V] = res[7] ^ dVal[7];
    end else if (isSbc(op)) begin
      // borrow chains in through the inverted carry term
      sum = {1'b0, dVal} + {1'b0, ~sVal} + {8'h00, ~cIn};
      low = {1'b0, dVal[3:0]} + {1'b0, ~sVal[3:0]} + {4'h0, ~cIn};
      res = sum[7:0];
      f[FLAG_C] = ~sum[8];
      f[FLAG_H] = ~low[4];
      f[FLAG_D] = 1'b1;
      f[FLAG_V] = (dVal[7] != sVal[7]) && (res[7] == sVal[7]);
    end
    if (isRot(op) || isSbc(op)) begin
      f[FLAG_Z] = (res == 8'h00);
      f[FLAG_S] = res[7];
    end
    return {f, res};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  rsr_state_type stateFf, nxt_state;
  logic [7:0]  opFf;
  logic [7:0]  dstAddrFf;
  logic [7:0]  srcAddrFf;
  logic [7:0]  dstValFf;
  logic [7:0]  resultFf;
  logic [7:0]  newFlagsFf;
  logic [7:0]  flagsFf;
  logic [7:0]  pcHiFf;
  logic [15:0] spFf;
  logic        wbFf;
  logic        doneFf;
  logic        illegalFf;
  logic        pcLoadFf;
  logic        retLowFf;
  logic [15:0] pcOutFf;
  logic [15:0] spOutFf;
  logic        enableFf;
  logic [15:0] countFf;
  logic        ackFf;
  logic [31:0] rdDataFf;

  ////////////////////////////////////////////////////////////////////////////
  // decode and datapath wires
  wire        busy      = (stateFf != ST_IDLE) || wbFf || retLowFf;
  wire        accept    = instrValid && instrReady;
  wire        srcImm    = (opFf == OP_SBC_RIM) || (opFf == OP_SBC_IRIM);
  wire        srcInd    = (opFf == OP_SBC_RIR) || (opFf == OP_SBC_RIR8);
  wire [15:0] calcImm   = aluCalc(opFf, memRdData, srcAddrFf, flagsFf);
  wire [15:0] calcSrc   = aluCalc(opFf, dstValFf, memRdData, flagsFf);
  wire        legalOp   = isRot(opcode) || isSbc(opcode) || opcode == OP_RET;
  wire        busAccess = avs_read || avs_write;
  wire        busTake   = busAccess && ackFf;
  wire        selCtrl   = avs_address == REG_CTRL;
  wire        selFlags  = avs_address == REG_FLAGS;
  wire        selStatus = avs_address == REG_STATUS;
  wire        selCount  = avs_address == REG_COUNT;
  wire [31:0] rdMux     = selCtrl   ? {31'h0, enableFf} :
                          selFlags  ? {24'h0, flagsFf} :
                          selStatus ? {23'h0, busy, opFf} :
                          selCount  ? {16'h0, countFf} : 32'h0000_0000;  // unmapped reads as zero
  wire        swFlagsWr = busTake && avs_write && selFlags && avs_byteenable[0];
  wire        swCtrlWr  = busTake && avs_write && selCtrl && avs_byteenable[0];

  // handshake and port outputs; the address mux reads only flops
  assign instrReady      = (stateFf == ST_IDLE) && !wbFf && !retLowFf && enableFf;
  assign instrDone       = doneFf;
  assign instrIllegal    = illegalFf;
  assign memRe           = stateFf inside {ST_RPTR, ST_ROPA, ST_CDST, ST_RSRC, ST_STKH, ST_STKL};
  assign memWe           = wbFf;
  assign memWrData       = resultFf;
  assign pcLoad          = pcLoadFf;
  assign spLoad          = pcLoadFf;
  assign pcOut           = pcOutFf;
  assign spOut           = spOutFf;
  assign flagsOut        = flagsFf;
  assign avs_readdata    = rdDataFf;
  assign avs_waitrequest = busAccess && !ackFf;

  // operand / stack address selection
  assign memAddr = (stateFf == ST_RPTR) ? {8'h00, dstAddrFf} :
                   (stateFf == ST_CDST || stateFf == ST_RSRC) ? {8'h00, srcAddrFf} :
                   (stateFf == ST_STKH) ? spFf :
                   (stateFf == ST_STKL) ? 16'(spFf + 16'h0001) :
                   {8'h00, dstAddrFf};

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    nxt_state = stateFf;
    case (stateFf)
      ST_IDLE: begin
        if (accept && legalOp && opcode == OP_RET) begin
          nxt_state = ST_STKH;
        end else if (accept && legalOp) begin
          nxt_state = dstInd(opcode) ? ST_RPTR : ST_ROPA;
        end
      end
      ST_RPTR: nxt_state = ST_CPTR;
      ST_CPTR: nxt_state = ST_ROPA;
      ST_ROPA: nxt_state = ST_CDST;
      ST_CDST: begin
        if (isRot(opFf) || srcImm) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_state = srcInd ? ST_CSPT : ST_CSRC;
        end
      end
      ST_CSPT: nxt_state = ST_RSRC;
      ST_RSRC: nxt_state = ST_CSRC;
      ST_CSRC: nxt_state = ST_IDLE;
      ST_STKH: nxt_state = ST_STKL;
      ST_STKL: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateFf <= ST_IDLE;
    end else begin
      stateFf <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand capture; the pointer byte replaces the register address so the
  // write-back lands on the pointed byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opFf      <= 8'h00;
      dstAddrFf <= 8'h00;
      srcAddrFf <= 8'h00;
      dstValFf  <= 8'h00;
      spFf      <= 16'h0000;
    end else if (accept) begin
      opFf      <= opcode;
      dstAddrFf <= dstField;
      srcAddrFf <= srcField;
      spFf      <= spIn;
    end else if (stateFf == ST_CPTR) begin
      dstAddrFf <= memRdData;
    end else if (stateFf == ST_CDST) begin
      dstValFf  <= memRdData;
    end else if (stateFf == ST_CSPT) begin
      srcAddrFf <= memRdData;
    end
  end

  // result, write-back strobe and completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resultFf   <= 8'h00;
      newFlagsFf <= 8'h00;
      wbFf       <= 1'b0;
      doneFf     <= 1'b0;
      illegalFf  <= 1'b0;
    end else begin
      wbFf      <= 1'b0;
      doneFf    <= wbFf || retLowFf || (accept && !legalOp);
      illegalFf <= accept && !legalOp;
      if (stateFf == ST_CDST && (isRot(opFf) || srcImm)) begin
        {newFlagsFf, resultFf} <= calcImm;
        wbFf <= 1'b1;
      end else if (stateFf == ST_CSRC) begin
        {newFlagsFf, resultFf} <= calcSrc;
        wbFf <= 1'b1;
      end
    end
  end

  // flags: the instruction update wins over a software write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flagsFf <= FLAGS_RST;
    end else if (wbFf) begin
      flagsFf <= newFlagsFf;
    end else if (swFlagsWr) begin
      flagsFf <= avs_writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // return: high byte first, then low byte; flags are never touched here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcHiFf   <= 8'h00;
      pcOutFf  <= 16'h0000;
      spOutFf  <= 16'h0000;
      pcLoadFf <= 1'b0;
      retLowFf <= 1'b0;
    end else begin
      // the low byte is only on the read port the cycle after the second read
      retLowFf <= (stateFf == ST_STKL);
      pcLoadFf <= retLowFf;
      if (stateFf == ST_STKL) begin
        pcHiFf  <= memRdData;
        spOutFf <= 16'(spFf + STACK_STEP);
      end
      if (retLowFf) begin
        pcOutFf <= {pcHiFf, memRdData};
      end
    end
  end

  // software enable gates new instructions
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enableFf <= CTRL_RST;
    end else if (swCtrlWr) begin
      enableFf <= avs_writedata[CTRL_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, read data registered in that cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ackFf    <= 1'b0;
      rdDataFf <= 32'h0000_0000;
      countFf  <= 16'h0000;
    end else begin
      ackFf <= busAccess && !ackFf;
      if (doneFf) begin
        countFf <= 16'(countFf + 16'h0001);
      end
      if (avs_read && !ackFf) begin
        rdDataFf <= rdMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_ret_pc_load: assert property ((stateFf == ST_STKL) |-> ##2 (pcLoad && spLoad) ##1 !pcLoad)
    else $error("return did not pulse pc load");
  chk_ret_sp_step: assert property ((stateFf == ST_STKL) |=> spOut == 16'($past(spFf) + 16'h0002))
    else $error("return stack pointer not advanced by two");
  chk_ret_flags_keep: assert property ((stateFf == ST_STKH) && !swFlagsWr |=> $stable(flagsFf))
    else $error("return changed flags");
  chk_rl_result: assert property (wbFf && (opFf == OP_RL_R) |-> resultFf == {dstValFf[6:0], dstValFf[7]}
                                  && newFlagsFf[FLAG_C] == dstValFf[7])
    else $error("rotate left wrong");
  chk_rlc_result: assert property (wbFf && (opFf == OP_RLC_R) |-> resultFf == {dstValFf[6:0], flagsFf[FLAG_C]})
    else $error("rotate left through carry wrong");
  chk_rr_result: assert property (wbFf && (opFf == OP_RR_IR) |-> resultFf == {dstValFf[0], dstValFf[7:1]})
    else $error("rotate right wrong");
  chk_rrc_result: assert property (wbFf && (opFf == OP_RRC_R) |-> resultFf == {flagsFf[FLAG_C], dstValFf[7:1]}
                                   && newFlagsFf[FLAG_C] == dstValFf[0])
    else $error("rotate right through carry wrong");
  chk_rot_zero_sign: assert property (wbFf && isRot(opFf) |=> flagsFf[FLAG_Z] == ($past(resultFf) == 8'h00)
                                      && flagsFf[FLAG_S] == $past(resultFf[7]))
    else $error("rotate zero or sign flag wrong");
  chk_rot_overflow: assert property (wbFf && isRot(opFf) |-> newFlagsFf[FLAG_V] == (resultFf[7] ^ dstValFf[7]))
    else $error("rotate overflow flag wrong");
  chk_rot_dh_keep: assert property (wbFf && isRot(opFf) |=> flagsFf[FLAG_D:FLAG_H] == $past(flagsFf[FLAG_D:FLAG_H]))
    else $error("rotate changed d or h");
  chk_sbc_borrow: assert property ((stateFf == ST_CSRC) |=> resultFf == 8'($past(dstValFf) - $past(memRdData)
                                   - {7'h00, $past(flagsFf[FLAG_C])}) && newFlagsFf[FLAG_D])
    else $error("subtract result wrong");
  chk_sbc_carry: assert property ((stateFf == ST_CSRC) |=> newFlagsFf[FLAG_C] == ({1'b0, $past(dstValFf)}
                                  < {1'b0, $past(memRdData)} + {8'h00, $past(flagsFf[FLAG_C])}))
    else $error("subtract carry wrong");
  chk_ind_writeback: assert property ((stateFf == ST_CPTR) |-> ##3 (memWe && memAddr == {8'h00, $past(memRdData, 3)}))
    else $error("indirect write-back to wrong address");

  cov_ret: cover property ((stateFf == ST_STKL) ##2 pcLoad);
  cov_rot_ind: cover property ((stateFf == ST_CPTR) ##3 memWe);
  cov_sbc_borrow: cover property (wbFf && isSbc(opFf) && newFlagsFf[FLAG_C]);
  cov_bus_flags: cover property (swFlagsWr);

endmodule

// file: dv/rsr_regfile_model.sv
// rsr_regfile_model: byte memory standing in for the register file and the stack.
// assumes the unit strobes on the rising edge of clk and wants read data one cycle later.
`timescale 1ns/10ps
module rsr_regfile_model (
  input  wire logic        clk,       // core clock
  input  wire logic        memRe,     // read strobe
  input  wire logic        memWe,     // write strobe
  input  wire logic [15:0] memAddr,   // byte address
  input  wire logic [7:0]  memWrData, // write data
  output logic [7:0]       memRdData  // read data, one cycle after memRe
);
  logic [7:0] mem [0:65535];
  ////////////////////////////////////////////////////////////////////////////
  // between reads the bus toggles, so a byte one cycle stale never passes for fresh data
  always @(posedge clk) begin
    if (memWe)
      mem[memAddr] <= memWrData;
    memRdData <= memRe ? mem[memAddr] : ~memRdData;
  end
  initial begin
    memRdData = 8'h00;
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
  end
endmodule

// file: dv/rsr_alu_tb_top.sv
// rsr_alu_tb_top: self-checking bench for the rotate/subtract/return unit.
// assumes the regfile model on the operand port and an Avalon master driven from here.
`timescale 1ns/10ps
module rsr_alu_tb_top;
  import rsr_alu_pkg::*;
  typedef struct {logic [15:0] addr; logic [7:0] val; logic [7:0] flg; logic isRet; logic ill;
                  logic [15:0] pc; logic [15:0] sp;} rsr_note_type;
  logic        clk, rst_n, instrValid, instrReady, instrDone, instrIllegal, memRe, memWe;
  logic        pcLoad, spLoad, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  opcode, dstField, srcField, memWrData, memRdData, flagsOut, v, f, res, d, s, pd, ps;
  logic [15:0] spIn, memAddr, pcOut, spOut, spv;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [8:0]  sum;
  logic [4:0]  low;
  logic        c;
  int          fail_count = 0;
  int          checks_done = 0;
  int          seed = 32'hff1a;
  int          nInstr = 0;
  rsr_note_type notes[$];
  logic [7:0]  rotOps [8] = '{OP_RL_R, OP_RL_IR, OP_RLC_R, OP_RLC_IR, OP_RR_R, OP_RR_IR, OP_RRC_R, OP_RRC_IR};
  logic [7:0]  sbcOps [6] = '{OP_SBC_RR, OP_SBC_RIR, OP_SBC_RR8, OP_SBC_RIR8, OP_SBC_RIM, OP_SBC_IRIM};

  rsr_alu uut (.clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instrReady(instrReady), .opcode(opcode),
    .dstField(dstField), .srcField(srcField), .spIn(spIn), .instrDone(instrDone), .instrIllegal(instrIllegal),
    .memRe(memRe), .memWe(memWe), .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
    .pcLoad(pcLoad), .pcOut(pcOut), .spLoad(spLoad), .spOut(spOut), .flagsOut(flagsOut),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  rsr_regfile_model mdl (.clk(clk), .memRe(memRe), .memWe(memWe), .memAddr(memAddr),
    .memWrData(memWrData), .memRdData(memRdData));

  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // avalon access: request held until waitrequest is sampled low at a rising edge, released right after it
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dat, input logic [3:0] be);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= dat;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    check("waitrequest", avs_waitrequest, 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // one instruction: offered until taken, expectation queued, then wait for its completion
  task automatic run(input logic [7:0] op, dd, ss, input logic [15:0] sp, input rsr_note_type nt);
    int n = 0;
    @(posedge clk);
    opcode <= op;
    dstField <= dd;
    srcField <= ss;
    spIn <= sp;
    instrValid <= 1'b1;
    do @(negedge clk); while (instrReady !== 1'b1);
    notes.push_back(nt);
    @(posedge clk);
    instrValid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (instrDone !== 1'b1 && n < 20);
    check("done", instrDone, 1'b1);
    nInstr++;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // result watcher: the oldest note is compared whenever an instruction finishes
  always @(negedge clk) begin : watch
    rsr_note_type e;
    if (rst_n && instrDone === 1'b1) begin
      e = notes.pop_front();
      check("illegal", instrIllegal, e.ill);
      check("flags", flagsOut, e.flg);
      if (e.isRet) begin
        check("pcOut", pcOut, e.pc);
        check("spOut", spOut, e.sp);
        check("spLoad", {pcLoad, spLoad}, 2'b11);
      end else if (!e.ill) begin
        check("result", mdl.mem[e.addr], e.val);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("unexpected watchdog: run did not finish");
    summarize();
  end

  initial begin
    {rst_n, instrValid, opcode, dstField, srcField, spIn, avs_read, avs_write} = '0;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, REG_CTRL, 0, 4'hF);
    check("ctrl reset", rd[0], CTRL_RST);
    bus(0, REG_FLAGS, 0, 4'hF);
    check("flags reset", rd[7:0], FLAGS_RST);
    bus(0, 4'h1, 0, 4'hF);
    check("unmapped", rd, 32'h0);
    bus(1, REG_FLAGS, 32'hFF, 4'hE);
    bus(1, REG_CTRL, 0, 4'hF);
    @(negedge clk);
    check("ready off", instrReady, 1'b0);
    bus(1, REG_CTRL, 1, 4'hF);
    bus(0, REG_FLAGS, 0, 4'hF);
    check("flags masked", rd[7:0], FLAGS_RST);
    // rotates, each form four times with random operand and flags
    for (int k = 0; k < 32; k++) begin
      d = 8'h40 + k[7:0];
      pd = d ^ 8'h80;
      v = $random(seed);
      f = $random(seed);
      mdl.mem[{8'h00, d}] = rotOps[k % 8][0] ? pd : v;
      mdl.mem[{8'h00, pd}] = v;
      bus(1, REG_FLAGS, {24'h0, f}, 4'hF);
      case (rotOps[k % 8] & 8'hFE)
        OP_RL_R:  {c, res} = {v[7], v[6:0], v[7]};
        OP_RLC_R: {c, res} = {v[7], v[6:0], f[FLAG_C]};
        OP_RR_R:  {c, res} = {v[0], v[0], v[7:1]};
        default:  {c, res} = {v[0], f[FLAG_C], v[7:1]};
      endcase
      run(rotOps[k % 8], d, 8'h00, 16'h0, '{rotOps[k % 8][0] ? {8'h00, pd} : {8'h00, d}, res,
          {c, res == 8'h00, res[7], res[7] ^ v[7], f[3:0]}, 1'b0, 1'b0, 16'h0, 16'h0});
    end
    // subtract with borrow over all six operand forms
    for (int k = 0; k < 36; k++) begin
      d = 8'h40 + k[7:0];
      s = 8'h10 + k[7:0];
      pd = d ^ 8'h80;
      ps = s ^ 8'h80;
      v = $random(seed);
      res = $random(seed);
      f = $random(seed);
      mdl.mem[{8'h00, pd}] = v;
      mdl.mem[{8'h00, d}] = (sbcOps[k % 6] == OP_SBC_IRIM) ? pd : v;
      mdl.mem[{8'h00, ps}] = res;
      mdl.mem[{8'h00, s}] = sbcOps[k % 6][0] ? ps : res;
      bus(1, REG_FLAGS, {24'h0, f}, 4'hF);
      sum = {1'b0, v} + {1'b0, ~res} + {8'h00, ~f[FLAG_C]};
      low = {1'b0, v[3:0]} + {1'b0, ~res[3:0]} + {4'h0, ~f[FLAG_C]};
      run(sbcOps[k % 6], d, (sbcOps[k % 6] >= OP_SBC_RIM) ? res : s, 16'h0,
          '{(sbcOps[k % 6] == OP_SBC_IRIM) ? {8'h00, pd} : {8'h00, d}, sum[7:0], {~sum[8], sum[7:0] == 8'h00,
          sum[7], (v[7] != res[7]) && (sum[7] == res[7]), 1'b1, ~low[4], f[1:0]}, 1'b0, 1'b0, 16'h0, 16'h0});
      check("source kept", mdl.mem[{8'h00, ps}], res);
    end
    // returns back to back, flags must survive
    f = $random(seed);
    bus(1, REG_FLAGS, {24'h0, f}, 4'hF);
    for (int k = 0; k < 4; k++) begin
      spv = {4'h8, 12'($random(seed))};
      v = $random(seed);
      res = $random(seed);
      mdl.mem[spv] = v;
      mdl.mem[spv + 16'h0001] = res;
      run(OP_RET, 8'h00, 8'h00, spv, '{16'h0, 8'h00, f, 1'b1, 1'b0, {v, res}, spv + 16'h0002});
    end
    bus(1, REG_STATUS, 32'hFFFF, 4'hF);
    bus(0, REG_STATUS, 0, 4'hF);
    check("status", rd[8:0], {1'b0, OP_RET});
    bus(0, REG_COUNT, 0, 4'hF);
    check("count", rd[15:0], nInstr[15:0]);
    run(8'h00, 8'h00, 8'h00, 16'h0, '{16'h0, 8'h00, f, 1'b0, 1'b1, 16'h0, 16'h0});
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule
